// ---- shared/lawmd_pkg.sv ----
// constants and carrier types for the literal and accumulator move decoder
`default_nettype none
package lawmd_pkg;
   // opcode patterns on the upper instruction bits
   localparam logic [7:0] LAWMD_OP_BANK_LOAD = 8'h01;
   localparam logic [7:0] LAWMD_OP_ACC_LOAD  = 8'h0e;
   localparam logic [6:0] LAWMD_OP_ACC_STORE = 7'h37;
   // field positions in the 16-bit instruction word
   localparam int LAWMD_OPC8_MSB  = 15;
   localparam int LAWMD_OPC8_LSB  = 8;
   localparam int LAWMD_OPC7_LSB  = 9;
   localparam int LAWMD_BANK_BIT  = 8;
   // address limit for indexed literal offset mode
   localparam logic [7:0] LAWMD_INDEX_LIMIT = 8'h5f;
   // upper nibble mask for the bank register
   localparam logic [7:0] LAWMD_BANK_MASK = 8'h0f;
   // reset values
   localparam logic [7:0] LAWMD_BANK_RST = 8'h00;
   localparam logic [7:0] LAWMD_ACC_RST  = 8'h00;
   localparam logic [15:0] LAWMD_INSN_RST = 16'h0000;

   // phase of the four-phase instruction cycle
   typedef enum logic [1:0] {
      LAWMD_Q1 = 2'b00,
      LAWMD_Q2 = 2'b01,
      LAWMD_Q3 = 2'b10,
      LAWMD_Q4 = 2'b11
   } lawmd_phase_t;

   // decoded instruction class
   typedef enum logic [1:0] {
      LAWMD_CLS_NONE  = 2'b00,
      LAWMD_CLS_BANK  = 2'b01,
      LAWMD_CLS_ACCLD = 2'b10,
      LAWMD_CLS_STORE = 2'b11
   } lawmd_class_t;

   // addressing mode of a store
   typedef enum logic [1:0] {
      LAWMD_AM_ACCESS  = 2'b00,
      LAWMD_AM_BANKED  = 2'b01,
      LAWMD_AM_INDEXED = 2'b10
   } lawmd_amode_t;

   // file register write request
   typedef struct packed {
      logic         we;
      lawmd_amode_t mode;
      logic [7:0]   bank;
      logic [7:0]   addr;
      logic [7:0]   data;
   } lawmd_fwrite_t;
endpackage : lawmd_pkg
`default_nettype wire

// ---- rtl/lawmd_decode.sv ----
// combinational opcode classifier for the three move instructions
`default_nettype none
module lawmd_decode
   import lawmd_pkg::*;
(
   // instruction word
   input  wire logic [15:0] insn,
   // decoded class
   output var  lawmd_class_t cls
);
   // store pattern uses seven bits, the eighth is the bank-mode bit
   always_comb begin
      if (insn[LAWMD_OPC8_MSB:LAWMD_OPC8_LSB] == LAWMD_OP_BANK_LOAD) begin
         cls = LAWMD_CLS_BANK;
      end else if (insn[LAWMD_OPC8_MSB:LAWMD_OPC8_LSB] == LAWMD_OP_ACC_LOAD) begin
         cls = LAWMD_CLS_ACCLD;
      end else if (insn[LAWMD_OPC8_MSB:LAWMD_OPC7_LSB] == LAWMD_OP_ACC_STORE) begin
         cls = LAWMD_CLS_STORE;
      end else begin
         cls = LAWMD_CLS_NONE;
      end
   end
endmodule // lawmd_decode
`default_nettype wire

// ---- rtl/lawmd_core.sv ----
// execute logic for bank load, accumulator load and accumulator store
`default_nettype none
// Function
// - bank load puts literal in bank register
// - bank register upper nibble stays zero
// - one word, one cycle, phased Q1 to Q4
// - accumulator load writes literal in Q4
// - store copies accumulator to file register
// - bank bit selects access or banked
// - extended set, low address uses indexing
module lawmd_core
   import lawmd_pkg::*;
(
   // clock and reset
   input  wire logic          clock,
   input  wire logic          rst_b,
   // instruction fetch, sampled at phase four
   input  wire logic [15:0]   insn_word,
   input  wire logic          ext_set_en,
   // architectural registers
   output logic [7:0]         bank_select_register,
   output logic [7:0]         accumulator,
   // file register write port
   output var lawmd_fwrite_t  fwrite,
   // phase indicator
   output var lawmd_phase_t   phase
);
   // complete module state
   typedef struct packed {
      lawmd_phase_t  phase;
      logic [15:0]   insn;
      lawmd_class_t  cls;
      logic [7:0]    lit;
      logic [7:0]    result;
      logic [7:0]    bank;
      logic [7:0]    acc;
      lawmd_fwrite_t fw;
   } lawmd_state_t;

   lawmd_state_t state_reg;
   lawmd_state_t state_next;
   lawmd_class_t dec_cls;

   // decoder looks at the latched word so the class is stable all cycle
   lawmd_decode u_decode (
      .insn (state_reg.insn),
      .cls  (dec_cls)
   );

   // next-state logic
   always_comb begin
      state_next = state_reg;
      state_next.fw.we = 1'b0;
      case (state_reg.phase)
         LAWMD_Q1: begin
            state_next.cls   = dec_cls;
            state_next.phase = LAWMD_Q2;
         end
         LAWMD_Q2: begin
            state_next.lit   = state_reg.insn[7:0];
            state_next.phase = LAWMD_Q3;
         end
         LAWMD_Q3: begin
            if (state_reg.cls == LAWMD_CLS_BANK) begin
               state_next.result = state_reg.lit & LAWMD_BANK_MASK;
            end else if (state_reg.cls == LAWMD_CLS_STORE) begin
               state_next.result = state_reg.acc;
            end else begin
               state_next.result = state_reg.lit;
            end
            state_next.phase = LAWMD_Q4;
         end
         LAWMD_Q4: begin
            // only destination updated, no flags exist here
            case (state_reg.cls)
               LAWMD_CLS_BANK: state_next.bank = state_reg.result;
               LAWMD_CLS_ACCLD: state_next.acc = state_reg.result;
               LAWMD_CLS_STORE: begin
                  state_next.fw.we   = 1'b1;
                  state_next.fw.data = state_reg.result;
                  state_next.fw.addr = state_reg.lit;
                  state_next.fw.bank = state_reg.bank;
                  if (state_reg.insn[LAWMD_BANK_BIT]) begin
                     state_next.fw.mode = LAWMD_AM_BANKED;
                  end else if (ext_set_en && (state_reg.lit <= LAWMD_INDEX_LIMIT)) begin
                     state_next.fw.mode = LAWMD_AM_INDEXED;
                  end else begin
                     state_next.fw.mode = LAWMD_AM_ACCESS;
                  end
               end
               default: state_next.bank = state_reg.bank;
            endcase
            // fetch next word here so it is ready for the next decode
            state_next.insn  = insn_word;
            state_next.phase = LAWMD_Q1;
         end
         default: state_next.phase = LAWMD_Q1;
      endcase
   end

   // state register; the first word is fetched on the first Q4
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= '{phase: LAWMD_Q4, insn: LAWMD_INSN_RST, cls: LAWMD_CLS_NONE,
                        lit: 8'h00, result: 8'h00, bank: LAWMD_BANK_RST,
                        acc: LAWMD_ACC_RST,
                        fw: '{we: 1'b0, mode: LAWMD_AM_ACCESS, bank: 8'h00,
                              addr: 8'h00, data: 8'h00}};
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs come straight from state flip-flops
   assign bank_select_register = state_reg.bank;
   assign accumulator          = state_reg.acc;
   assign fwrite               = state_reg.fw;
   assign phase                = state_reg.phase;
endmodule // lawmd_core
`default_nettype wire

// ---- dv/lawmd_monitor.sv ----
// concurrent checks on the ports of the move decoder core
`default_nettype none
module lawmd_monitor
   import lawmd_pkg::*;
(
   // clock and reset
   input wire logic          clock,
   input wire logic          rst_b,
   // fetch side
   input wire logic [15:0]   insn_word,
   input wire logic          ext_set_en,
   // results
   input wire logic [7:0]    bank_select_register,
   input wire logic [7:0]    accumulator,
   input wire lawmd_fwrite_t fwrite,
   input wire lawmd_phase_t  phase
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // a word is taken on the edge that ends phase four
   wire tk = phase == LAWMD_Q4;
   a_bank_load:
      assert property (tk && insn_word[15:8] == 8'h01 |=> ##4
         bank_select_register == {4'h0, $past(insn_word[3:0], 5)}) else $error("bank load wrong");
   a_bank_upper:
      assert property (bank_select_register[7:4] == 4'h0) else $error("bank upper nibble set");
   a_phase_order:
      assert property (phase == LAWMD_Q1 |=> phase == LAWMD_Q2 ##1 phase == LAWMD_Q3
         ##1 phase == LAWMD_Q4 ##1 phase == LAWMD_Q1) else $error("phase order wrong");
   a_acc_load:
      assert property (tk && insn_word[15:8] == 8'h0e |=> ##4
         accumulator == $past(insn_word[7:0], 5)) else $error("accumulator load wrong");
   a_store_data:
      assert property (tk && insn_word[15:9] == 7'h37 |=> ##4 fwrite.we
         && fwrite.addr == $past(insn_word[7:0], 5) && fwrite.data == accumulator
         && fwrite.bank == bank_select_register) else $error("store write wrong");
   a_store_mode:
      assert property (tk && insn_word[15:9] == 7'h37 |=> ##4 fwrite.mode == ($past(insn_word[8], 5)
         ? LAWMD_AM_BANKED : ($past(ext_set_en) && $past(insn_word[7:0], 5) <= 8'h5f)
         ? LAWMD_AM_INDEXED : LAWMD_AM_ACCESS)) else $error("store mode wrong");
   a_we_pulse:
      assert property (fwrite.we |=> !fwrite.we) else $error("write strobe too long");
   a_no_write:
      assert property (tk && insn_word[15:9] != 7'h37 |=> ##4 !fwrite.we) else $error("stray write");
   a_bank_keep:
      assert property (tk && insn_word[15:8] != 8'h01 |=> ##4 $stable(bank_select_register))
         else $error("bank changed");
endmodule // lawmd_monitor
bind lawmd_core lawmd_monitor i_mon (.clock(clock), .rst_b(rst_b), .insn_word(insn_word),
   .ext_set_en(ext_set_en), .bank_select_register(bank_select_register),
   .accumulator(accumulator), .fwrite(fwrite), .phase(phase));
`default_nettype wire

// ---- dv/tb_top.sv ----
// self-checking bench for the move decoder core
`default_nettype none
module tb_top
   import lawmd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic          clock, rst_b, ext_set_en;
   logic [15:0]   insn_word;
   logic [7:0]    bank_select_register, accumulator, exp_bank, exp_acc;
   lawmd_fwrite_t fwrite, exp_fw;
   lawmd_phase_t  phase;
   int            n_fail, total_checks;
   // full literal, load then store, index limit on both sides, banked store
   logic [15:0]   corner [6] = '{16'h01ff, 16'h0ea5, 16'h6e5f, 16'h6e60, 16'h6f5f, 16'h0125};
   lawmd_core i_dut (.clock(clock), .rst_b(rst_b), .insn_word(insn_word),
      .ext_set_en(ext_set_en), .bank_select_register(bank_select_register),
      .accumulator(accumulator), .fwrite(fwrite), .phase(phase));
   // 20 MHz core clock
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // three quarters of the words are forced onto the three opcodes, the rest mostly do nothing
   function automatic logic [15:0] rnd();
      logic [15:0] w;
      w = 16'($urandom);
      case ($urandom % 4)
         0: w[15:8] = 8'h01;
         1: w[15:8] = 8'h0e;
         2: w[15:9] = 7'h37;
         default: ;
      endcase
      return w;
   endfunction
   // one instruction cycle; results of the previous word land on its first edge
   // the mode bit is sampled at the store's own Q4 edge, so it changes only after the take edge
   task automatic step(input logic [15:0] w, input logic e);
      insn_word <= w;
      @(posedge clock);
      ext_set_en <= e;
      #1;
      chk(32'(bank_select_register), 32'(exp_bank));
      chk(32'(accumulator), 32'(exp_acc));
      chk(32'(fwrite.we), 32'(exp_fw.we));
      if (exp_fw.we) chk(32'(fwrite), 32'(exp_fw));
      exp_fw.we = 1'b0;
      if (w[15:8] == 8'h01) exp_bank = {4'h0, w[3:0]};
      if (w[15:8] == 8'h0e) exp_acc = w[7:0];
      if (w[15:9] == 7'h37) exp_fw = '{1'b1, w[8] ? LAWMD_AM_BANKED : (e && w[7:0] <= 8'h5f)
         ? LAWMD_AM_INDEXED : LAWMD_AM_ACCESS, exp_bank, w[7:0], exp_acc};
      repeat (3) @(posedge clock);
   endtask
   // main sequence: reset, corner words, random words, one flushing word
   initial begin
      rst_b = 1'b0;
      insn_word = 16'h0000;
      ext_set_en = 1'b0;
      {exp_bank, exp_acc, exp_fw, n_fail, total_checks} = '0;
      void'($urandom(32'hbb816fc9));
      repeat (3) @(posedge clock);
      rst_b <= 1'b1;
      foreach (corner[i]) step(corner[i], 1'b1);
      for (int i = 0; i < 200; i++) step(rnd(), 1'($urandom));
      step(16'h0000, 1'b0);
      test_done();
   end
   // about 210 instructions of 200 ns each, with ample margin
   initial begin
      #100000;
      n_fail++;
      test_done();
   end
endmodule // tb_top
`default_nettype wire
